/* wolfd_defs.svh */
`ifndef WOLFD_DEFS_SVH
`define WOLFD_DEFS_SVH

// ----------------------------------------
// host register offsets
// ----------------------------------------
`define WOLFD_OFS_CMD 5'h00
`define WOLFD_OFS_MASK0 5'h01
`define WOLFD_OFS_CFG_LAST 5'h09
`define WOLFD_OFS_WAKE_CONTROL_STATUS 5'h0A
`define WOLFD_OFS_PM 5'h0B

// ----------------------------------------
// command / power management fields
// ----------------------------------------
`define WOLFD_PAGE_HI 7
`define WOLFD_PAGE_LO 6
`define WOLFD_PAGE3 2'h3
`define WOLFD_PM_HI 1
`define WOLFD_PM_LO 0
`define WOLFD_PM_LIGHT 2'h1
`define WOLFD_CMD_RST 8'h00
`define WOLFD_PM_RST 8'h00
`define WOLFD_WAKE_CONTROL_STATUS_RST 8'h00

// ----------------------------------------
// wake control/status fields
// ----------------------------------------
`define WOLFD_EN_LINK 0
`define WOLFD_EN_MAGIC 1
`define WOLFD_EN_FRAME 2
`define WOLFD_EV_LINK 4
`define WOLFD_EV_MAGIC 5
`define WOLFD_EV_FRAME 6
`define WOLFD_WAKE_CONTROL_STATUS_EN_MSK 8'h07
`define WOLFD_WAKE_CONTROL_STATUS_EV_MSK 8'h70

// ----------------------------------------
// configuration word layout
// ----------------------------------------
`define WOLFD_NWORDS 9
`define WOLFD_W_CRC10 4'h4
`define WOLFD_W_OFST 4'h6
`define WOLFD_W_LAST 4'h7
`define WOLFD_W_CMD 4'h8
`define WOLFD_CMD_STRIDE 4
`define WOLFD_CMD_EN 0
`define WOLFD_CASCADE_BIT 16
`define WOLFD_BYTE 8
`define WOLFD_HALF 16

// ----------------------------------------
// frame matching constants
// ----------------------------------------
`define WOLFD_CRC_INIT 16'hFFFF
`define WOLFD_CRC_POLY 16'h8005
`define WOLFD_WIN 11'h020
`define WOLFD_IDX_MAX 11'h7FF
`define WOLFD_MAGIC_SYNC 3'h6
`define WOLFD_MAC_LAST 3'h5
`define WOLFD_MAGIC_LAST_REP 5'h0F
`define WOLFD_BYTE_FF 8'hFF

`endif

/* wolfd_pkg.sv */
`include "wolfd_defs.svh"

package wolfd_pkg;

  typedef logic [`WOLFD_NWORDS-1:0][31:0] wolfd_words_t;

  typedef enum logic [1:0] {
    MG_HUNT = 2'b00,
    MG_MAC = 2'b01,
    MG_DONE = 2'b10
  } wolfd_mg_e_t;

  typedef struct packed {
    wolfd_words_t word;
    logic [7:0] rdata;
  } wolfd_mem_t;

  typedef struct packed {
    logic [15:0] crc;
    logic last_ok;
  } wolfd_flt_t;

  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] wake_control_status;
    logic [7:0] pm;
    logic [7:0] rdata;
    logic from_mem;
    logic [10:0] byte_idx;
    logic prev_link;
    wolfd_mg_e_t mg;
    logic [2:0] ff_cnt;
    logic [2:0] mac_pos;
    logic [4:0] mac_rep;
    logic [1:0] stage;
  } wolfd_st_t;

  // bits enter lsb first, as they leave the wire
  function automatic logic [15:0] wolfd_crc16_byte(input logic [15:0] crc_in, input logic [7:0] data);
    logic [15:0] c;
    logic fb;
    c = crc_in;
    fb = 1'b0;
    for (int i = 0; i < 8; i++) begin
      fb = c[15] ^ data[i];
      c = {c[14:0], 1'b0};
      if (fb) begin
        c = c ^ `WOLFD_CRC_POLY;
      end
    end
    return c;
  endfunction

  function automatic logic [4:0] wolfd_top_bit(input logic [31:0] mask);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (mask[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

endpackage

/* wolfd_cfg_mem.sv */
`timescale 1ns/1ns
`include "wolfd_defs.svh"

module wolfd_cfg_mem
  import wolfd_pkg::*;
(
  input wire logic ref_clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic wr_en, // byte write strobe
  input wire logic [3:0] wr_idx, // word index
  input wire logic [7:0] wr_byte, // byte shifted in at the top
  input wire logic rd_en, // read strobe
  input wire logic [3:0] rd_idx, // word index to read
  output logic [7:0] rd_byte, // low byte of the word, registered
  output wolfd_words_t words // all words, for the filters
);

  wolfd_mem_t st_ff;
  wolfd_mem_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (wr_en && (wr_idx < 4'(`WOLFD_NWORDS))) begin
      nxt_st.word[wr_idx] = {wr_byte, st_ff.word[wr_idx][31:8]};
    end
    if (rd_en) begin
      nxt_st.rdata = (rd_idx < 4'(`WOLFD_NWORDS)) ? st_ff.word[rd_idx][7:0] : 8'h00;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_byte = st_ff.rdata;
  assign words = st_ff.word;

endmodule

/* wolfd_filter.sv */
`timescale 1ns/1ns
`include "wolfd_defs.svh"

module wolfd_filter
  import wolfd_pkg::*;
(
  input wire logic ref_clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic byte_vld, // frame byte present, detection mode
  input wire logic sof, // first byte of a frame
  input wire logic [10:0] byte_idx, // index of the present byte
  input wire logic [7:0] data, // frame byte
  input wire logic [31:0] mask, // byte mask
  input wire logic [7:0] offset, // programmed offset byte
  input wire logic [15:0] crc_exp, // expected crc
  input wire logic [7:0] last_val, // expected last masked byte
  output logic hit // crc and last byte both match so far
);

  wolfd_flt_t st_ff;
  wolfd_flt_t nxt_st;
  logic [10:0] base;
  logic [10:0] rel;
  logic in_win;
  logic [4:0] last_idx;

  assign base = {2'b00, offset, 1'b0};
  assign rel = byte_idx - base;
  assign in_win = (byte_idx >= base) && (rel < `WOLFD_WIN);
  assign last_idx = wolfd_top_bit(mask);

  always_comb begin
    nxt_st = st_ff;
    if (byte_vld) begin
      if (sof) begin
        nxt_st.crc = `WOLFD_CRC_INIT;
        nxt_st.last_ok = 1'b0;
      end
      if (in_win && mask[rel[4:0]]) begin
        nxt_st.crc = wolfd_crc16_byte(nxt_st.crc, data);
      end
      if (in_win && (rel[4:0] == last_idx)) begin
        nxt_st.last_ok = (data == last_val);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // an empty mask selects no byte and can never match
  assign hit = (mask != 32'h0000_0000) && (st_ff.crc == crc_exp) && st_ff.last_ok;

endmodule

/* wolfd_detector.sv */
`timescale 1ns/1ns
`include "wolfd_defs.svh"

module wolfd_detector
  import wolfd_pkg::*;
(
  input wire logic ref_clk, // 10 MHz system clock
  input wire logic rstn, // async reset, active low
  input wire logic [4:0] reg_addr, // host register offset
  input wire logic reg_wr, // host write strobe
  input wire logic reg_rd, // host read strobe
  input wire logic [7:0] reg_wdata, // host write data
  output logic [7:0] reg_rdata, // host read data
  input wire logic rx_valid, // receive byte strobe
  input wire logic rx_sof, // with rx_valid: first byte of frame
  input wire logic [7:0] rx_data, // receive byte
  input wire logic rx_eof, // frame end strobe, no data
  input wire logic rx_good, // with rx_eof: frame fcs good
  input wire logic rx_addr_match, // with rx_eof: address filter passed
  input wire logic [47:0] station_mac, // own mac, first byte in [47:40]
  input wire logic phy_link, // phy link status level
  output logic wake_mode, // detection mode active
  output logic normal_rx_en, // normal reception allowed
  output logic wake_out // wake indication to host
);

  // ----------------------------------------
  // state and decode
  // ----------------------------------------
  wolfd_st_t st_ff;
  wolfd_st_t nxt_st;
  wolfd_words_t words;
  logic [7:0] mem_rd;
  logic page3;
  logic mem_sel;
  logic [3:0] mem_idx;
  logic [10:0] cur_idx;
  logic frame_byte;
  logic [3:0] hit;
  logic [3:0] flt_en;
  logic [3:0] hit_q;
  logic [3:0] pass;
  logic cascade;
  logic frame_wake;
  logic magic_wake;
  logic link_wake;
  logic sel_cmd;
  logic sel_wake_control_status;
  logic sel_pm;
  logic eof_eval;

  function automatic logic [7:0] mac_byte(input logic [47:0] mac, input logic [2:0] pos);
    logic [7:0] b;
    b = 8'h00;
    case (pos)
      3'h0: b = mac[47:40];
      3'h1: b = mac[39:32];
      3'h2: b = mac[31:24];
      3'h3: b = mac[23:16];
      3'h4: b = mac[15:8];
      3'h5: b = mac[7:0];
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // page 0 only reaches the command register, everything else needs page 3
  function automatic logic reg_sel(input logic [4:0] addr, input logic [4:0] ofs, input logic pg3);
    logic hit_ofs;
    hit_ofs = (addr == ofs);
    if (ofs != `WOLFD_OFS_CMD) begin
      hit_ofs = hit_ofs && pg3;
    end
    return hit_ofs;
  endfunction

  assign page3 = (st_ff.cmd[`WOLFD_PAGE_HI:`WOLFD_PAGE_LO] == `WOLFD_PAGE3);
  assign mem_sel = page3 && (reg_addr >= `WOLFD_OFS_MASK0) && (reg_addr <= `WOLFD_OFS_CFG_LAST);
  assign mem_idx = 4'(reg_addr - `WOLFD_OFS_MASK0);
  assign wake_mode = ((st_ff.wake_control_status & `WOLFD_WAKE_CONTROL_STATUS_EN_MSK) != 8'h00)
                     && (st_ff.pm[`WOLFD_PM_HI:`WOLFD_PM_LO] == `WOLFD_PM_LIGHT);
  assign normal_rx_en = !wake_mode;
  // every frame is inspected in sleep, address is only checked at the end
  assign frame_byte = wake_mode && rx_valid;
  assign cur_idx = rx_sof ? 11'h000 : st_ff.byte_idx;
  assign cascade = words[`WOLFD_W_CMD][`WOLFD_CASCADE_BIT];
  assign sel_cmd = reg_sel(reg_addr, `WOLFD_OFS_CMD, page3);
  assign sel_wake_control_status = reg_sel(reg_addr, `WOLFD_OFS_WAKE_CONTROL_STATUS, page3);
  assign sel_pm = reg_sel(reg_addr, `WOLFD_OFS_PM, page3);
  // a frame with a bad fcs is never judged
  assign eof_eval = wake_mode && rx_eof && rx_good;

  // ----------------------------------------
  // configuration store
  // ----------------------------------------
  wolfd_cfg_mem u_cfg (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .wr_en(reg_wr && mem_sel),
    .wr_idx(mem_idx),
    .wr_byte(reg_wdata),
    .rd_en(reg_rd && mem_sel),
    .rd_idx(mem_idx),
    .rd_byte(mem_rd),
    .words(words)
  );

  // ----------------------------------------
  // four wake-up frame filters
  // ----------------------------------------
  for (genvar g = 0; g < 4; g++) begin : g_flt
    assign flt_en[g] = words[`WOLFD_W_CMD][`WOLFD_CMD_STRIDE*g+`WOLFD_CMD_EN];
    wolfd_filter u_flt (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .byte_vld(frame_byte),
      .sof(rx_sof),
      .byte_idx(cur_idx),
      .data(rx_data),
      .mask(words[g]),
      .offset(words[`WOLFD_W_OFST][`WOLFD_BYTE*g +: `WOLFD_BYTE]),
      .crc_exp(words[`WOLFD_W_CRC10 + 4'(g/2)][`WOLFD_HALF*(g%2) +: `WOLFD_HALF]),
      .last_val(words[`WOLFD_W_LAST][`WOLFD_BYTE*g +: `WOLFD_BYTE]),
      .hit(hit[g])
    );
  end

  assign hit_q = hit & flt_en & {4{rx_addr_match}};
  // a disabled link of the chain passes on any judged frame, one frame per link
  assign pass = hit_q | ~flt_en;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    frame_wake = 1'b0;
    magic_wake = 1'b0;
    link_wake = 1'b0;

    // ----------------------------------------
    // host register access
    // ----------------------------------------
    if (reg_rd) begin
      nxt_st.from_mem = mem_sel;
      nxt_st.rdata = 8'h00;
      if (sel_cmd) begin
        nxt_st.rdata = st_ff.cmd;
      end else if (sel_wake_control_status) begin
        nxt_st.rdata = st_ff.wake_control_status;
      end else if (sel_pm) begin
        nxt_st.rdata = st_ff.pm;
      end
    end
    if (reg_wr) begin
      if (sel_cmd) begin
        nxt_st.cmd = reg_wdata;
      end else if (sel_wake_control_status) begin
        nxt_st.wake_control_status = (reg_wdata & `WOLFD_WAKE_CONTROL_STATUS_EN_MSK) | (st_ff.wake_control_status & `WOLFD_WAKE_CONTROL_STATUS_EV_MSK & ~reg_wdata);
      end else if (sel_pm) begin
        nxt_st.pm = reg_wdata;
      end
    end

    // ----------------------------------------
    // link change, tracked always so entry into sleep gives no false event
    // ----------------------------------------
    nxt_st.prev_link = phy_link;
    link_wake = wake_mode && st_ff.wake_control_status[`WOLFD_EN_LINK] && (phy_link != st_ff.prev_link);

    // ----------------------------------------
    // frame byte counter
    // ----------------------------------------
    if (frame_byte) begin
      nxt_st.byte_idx = (cur_idx == `WOLFD_IDX_MAX) ? `WOLFD_IDX_MAX : cur_idx + 11'h001;
    end

    // ----------------------------------------
    // magic pattern: six sync bytes then sixteen copies of the mac
    // ----------------------------------------
    if (frame_byte) begin
      if (rx_sof) begin
        nxt_st.mg = MG_HUNT;
        nxt_st.ff_cnt = 3'h0;
      end
      case (nxt_st.mg)
        MG_HUNT: begin
          if (rx_data == `WOLFD_BYTE_FF) begin
            nxt_st.ff_cnt = nxt_st.ff_cnt + 3'h1;
            if (nxt_st.ff_cnt == `WOLFD_MAGIC_SYNC) begin
              nxt_st.mg = MG_MAC;
              nxt_st.mac_pos = 3'h0;
              nxt_st.mac_rep = 5'h00;
            end
          end else begin
            nxt_st.ff_cnt = 3'h0;
          end
        end
        MG_MAC: begin
          if (rx_data == mac_byte(station_mac, st_ff.mac_pos)) begin
            if (st_ff.mac_pos == `WOLFD_MAC_LAST) begin
              nxt_st.mac_pos = 3'h0;
              nxt_st.mac_rep = st_ff.mac_rep + 5'h01;
              if (st_ff.mac_rep == `WOLFD_MAGIC_LAST_REP) begin
                nxt_st.mg = MG_DONE;
              end
            end else begin
              nxt_st.mac_pos = st_ff.mac_pos + 3'h1;
            end
          end else if ((rx_data == `WOLFD_BYTE_FF) && (st_ff.mac_pos == 3'h0) && (st_ff.mac_rep == 5'h00)) begin
            nxt_st.mg = MG_MAC;
          end else begin
            // a restart may already begin with this byte
            nxt_st.mg = MG_HUNT;
            nxt_st.ff_cnt = (rx_data == `WOLFD_BYTE_FF) ? 3'h1 : 3'h0;
          end
        end
        MG_DONE: begin
          nxt_st.mg = MG_DONE;
        end
        default: begin
          nxt_st.mg = MG_HUNT;
        end
      endcase
    end

    // ----------------------------------------
    // end of frame evaluation
    // ----------------------------------------
    if (eof_eval) begin
      magic_wake = st_ff.wake_control_status[`WOLFD_EN_MAGIC] && (st_ff.mg == MG_DONE) && rx_addr_match;
      if (st_ff.wake_control_status[`WOLFD_EN_FRAME]) begin
        if (cascade) begin
          // chain: each enabled stage must match in turn, last stage wakes
          if (pass[st_ff.stage]) begin
            nxt_st.stage = st_ff.stage + 2'h1;
            frame_wake = (st_ff.stage == 2'h3);
          end
        end else begin
          frame_wake = (hit_q != 4'h0);
        end
      end
    end
    if (wake_mode && rx_eof) begin
      nxt_st.mg = MG_HUNT;
      nxt_st.ff_cnt = 3'h0;
    end
    if (!wake_mode) begin
      nxt_st.stage = 2'h0;
      nxt_st.mg = MG_HUNT;
      nxt_st.ff_cnt = 3'h0;
    end

    // ----------------------------------------
    // event bits: hardware set wins over a host clear in the same cycle
    // ----------------------------------------
    if (link_wake) begin
      nxt_st.wake_control_status[`WOLFD_EV_LINK] = 1'b1;
    end
    if (magic_wake) begin
      nxt_st.wake_control_status[`WOLFD_EV_MAGIC] = 1'b1;
    end
    if (frame_wake) begin
      nxt_st.wake_control_status[`WOLFD_EV_FRAME] = 1'b1;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
      st_ff.cmd <= `WOLFD_CMD_RST;
      st_ff.wake_control_status <= `WOLFD_WAKE_CONTROL_STATUS_RST;
      st_ff.pm <= `WOLFD_PM_RST;
      st_ff.mg <= MG_HUNT;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.from_mem ? mem_rd : st_ff.rdata;
  assign wake_out = ((st_ff.wake_control_status & `WOLFD_WAKE_CONTROL_STATUS_EV_MSK) != 8'h00);

endmodule

/* wolfd_host_model.sv */
`timescale 1ns/1ns
`include "wolfd_defs.svh"

module wolfd_host_model (
  input wire logic ref_clk, // system clock
  output logic [4:0] reg_addr, // register offset
  output logic reg_wr, // write strobe
  output logic reg_rd, // read strobe
  output logic [7:0] reg_wdata, // write data
  input wire logic [7:0] reg_rdata // read data
);
  initial begin
    reg_addr = 5'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // ----------------------------------------
  // bus cycles, one strobe cycle each
  // ----------------------------------------
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d; // released data must not look held
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
  // low byte first, so it ends up in bits 7:0
  task automatic cfg(input logic [4:0] a, input logic [31:0] w);
    for (int i = 0; i < 4; i++) begin
      wr(a, w[8 * i +: 8]);
    end
  endtask
  task automatic page3();
    wr(`WOLFD_OFS_CMD, 8'hC2);
  endtask
endmodule

/* wolfd_detector_asserts.sv */
`timescale 1ns/1ns
`include "wolfd_defs.svh"

module wolfd_detector_asserts (
  input wire logic ref_clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic [4:0] reg_addr, // register offset
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [7:0] reg_wdata, // write data
  input wire logic [7:0] reg_rdata, // read data
  input wire logic wake_mode, // detection mode
  input wire logic normal_rx_en, // reception allowed
  input wire logic wake_out // wake indication
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic pg3_ff;
  // shadow of the page bits, the command register is not visible here
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pg3_ff <= 1'b0;
    end else if (reg_wr && reg_addr == `WOLFD_OFS_CMD) begin
      pg3_ff <= reg_wdata[7:6] == 2'h3;
    end
  end
  a_mode_rx_excl: assert property (normal_rx_en == !wake_mode)
    else $error("reception and detection not exclusive");
  a_mode_by_write: assert property ($changed(wake_mode) |-> $past(reg_wr) && $past(pg3_ff))
    else $error("mode changed without a page 3 write");
  a_page_gate: assert property (reg_wr && !pg3_ff |=> $stable(wake_mode))
    else $error("write off page 3 changed mode");
  a_off_page_read: assert property (reg_rd && !pg3_ff && reg_addr != `WOLFD_OFS_CMD |=> reg_rdata == 8'h00)
    else $error("read off page 3 not zero");
  a_unmapped_read: assert property (reg_rd && reg_addr > `WOLFD_OFS_PM |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_wake_sticky: assert property (wake_out && !(reg_wr && reg_addr == `WOLFD_OFS_WAKE_CONTROL_STATUS) |=> wake_out)
    else $error("wake dropped without a clear");
  a_event_in_mode: assert property ($rose(wake_out) |-> $past(wake_mode))
    else $error("wake raised outside detection mode");
  a_clear_idle: assert property (reg_wr && pg3_ff && reg_addr == `WOLFD_OFS_WAKE_CONTROL_STATUS && reg_wdata == 8'h70
    && !wake_mode |=> !wake_out)
    else $error("wake not cleared");
endmodule

bind wolfd_detector wolfd_detector_asserts i_chk (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .wake_mode(wake_mode),
  .normal_rx_en(normal_rx_en), .wake_out(wake_out));

/* wolfd_detector_tb_top.sv */
`timescale 1ns/1ns
`include "wolfd_defs.svh"

module wolfd_detector_tb_top;
  localparam logic [47:0] MAC = 48'h02_11_22_33_44_55;
  localparam logic [31:0] MSK = 32'h0000_0105;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic rx_valid = 1'b0;
  logic rx_sof = 1'b0;
  logic [7:0] rx_data = 8'h00;
  logic rx_eof = 1'b0;
  logic rx_good = 1'b0;
  logic rx_addr_match = 1'b0;
  logic phy_link = 1'b0;
  logic wake_mode;
  logic normal_rx_en;
  logic wake_out;
  logic [7:0] fb [0:127];
  int flen = 0;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;

  wolfd_host_model h (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  wolfd_detector i_dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_sof(rx_sof),
    .rx_data(rx_data), .rx_eof(rx_eof), .rx_good(rx_good), .rx_addr_match(rx_addr_match),
    .station_mac(MAC), .phy_link(phy_link), .wake_mode(wake_mode), .normal_rx_en(normal_rx_en),
    .wake_out(wake_out));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] d;
    h.rd(a, d);
    chk(d, e);
  endtask
  task automatic wchk(input logic e);
    chk({7'h00, wake_out}, {7'h00, e});
  endtask
  function automatic logic [15:0] crc_of(input logic [31:0] m, input int base);
    logic [15:0] c;
    c = `WOLFD_CRC_INIT;
    for (int i = 0; i < 32; i++) begin
      for (int b = 0; m[i] && b < 8; b++) begin
        c = {c[14:0], 1'b0} ^ ((c[15] ^ fb[base + i][b]) ? `WOLFD_CRC_POLY : 16'h0000);
      end
    end
    return c;
  endfunction
  // eof in its own cycle; wake is visible by the final falling edge
  task automatic send(input logic am);
    for (int i = 0; i < flen; i++) begin
      @(negedge ref_clk);
      rx_valid = 1'b1;
      rx_sof = (i == 0);
      rx_data = fb[i];
    end
    @(negedge ref_clk);
    rx_valid = 1'b0;
    rx_sof = 1'b0;
    rx_data = ~rx_data;
    rx_eof = 1'b1;
    rx_good = 1'b1;
    rx_addr_match = am;
    @(negedge ref_clk);
    rx_eof = 1'b0;
    rx_good = 1'b0;
    rx_addr_match = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic clr();
    h.wr(`WOLFD_OFS_WAKE_CONTROL_STATUS, 8'h77);
  endtask
  // leaving the mode first also restarts the cascade chain
  task automatic setup(input logic [31:0] cmdw, input logic [7:0] lastv);
    h.wr(`WOLFD_OFS_PM, 8'h00);
    h.cfg(`WOLFD_OFS_MASK0, MSK);
    h.cfg(5'h04, MSK);
    h.cfg(5'h05, {16'h0000, crc_of(MSK, 4)});
    h.cfg(5'h06, {crc_of(MSK, 4), 16'h0000});
    h.cfg(5'h07, 32'h0200_0002);
    h.cfg(5'h08, {lastv, 16'h0000, lastv});
    h.cfg(`WOLFD_OFS_CFG_LAST, cmdw);
    h.wr(`WOLFD_OFS_PM, 8'h01);
    clr();
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk({6'h00, wake_mode, normal_rx_en}, 8'h01);
    h.wr(`WOLFD_OFS_WAKE_CONTROL_STATUS, 8'h07);
    h.page3();
    rchk(`WOLFD_OFS_WAKE_CONTROL_STATUS, 8'h00);
    rchk(`WOLFD_OFS_PM, 8'h00);
    h.wr(5'h0C, 8'hFF);
    rchk(5'h0C, 8'h00);
    for (int i = 0; i < 4; i++) begin
      h.wr(`WOLFD_OFS_MASK0, 8'(32'h0040_0807 >> (8 * i)));
      rchk(`WOLFD_OFS_MASK0, (i == 3) ? 8'h07 : 8'h00);
    end
    $display("test reset done");
  endtask
  task automatic t_frame();
    for (int i = 0; i < 40; i++) begin
      fb[i] = 8'(i * 7 + 3);
    end
    flen = 40;
    setup(32'h0000_0001, fb[12]);
    chk({6'h00, wake_mode, normal_rx_en}, 8'h02);
    send(1'b1);
    wchk(1'b1);
    rchk(`WOLFD_OFS_WAKE_CONTROL_STATUS, 8'h47);
    clr();
    wchk(1'b0);
    send(1'b0);
    wchk(1'b0);
    fb[5] = ~fb[5];
    send(1'b1);
    wchk(1'b1);
    clr();
    fb[6] = fb[6] ^ 8'h01;
    send(1'b1);
    wchk(1'b0);
    fb[6] = fb[6] ^ 8'h01;
    setup(32'h0000_1000, fb[12]);
    send(1'b1);
    wchk(1'b1);
    setup(32'h0000_0001, ~fb[12]);
    send(1'b1);
    wchk(1'b0);
    $display("test frame done");
  endtask
  task automatic t_cascade();
    setup(32'h0001_0001, fb[12]);
    for (int k = 0; k < 4; k++) begin
      send(1'b1);
      wchk(k == 3);
    end
    $display("test cascade done");
  endtask
  task automatic t_magic();
    for (int i = 0; i < 102; i++) begin
      fb[i] = (i < 6) ? 8'hFF : MAC[47 - 8 * ((i - 6) % 6) -: 8];
    end
    flen = 102;
    setup(32'h0000_0000, 8'h00);
    send(1'b1);
    wchk(1'b1);
    rchk(`WOLFD_OFS_WAKE_CONTROL_STATUS, 8'h27);
    clr();
    flen = 101;
    send(1'b1);
    wchk(1'b0);
    $display("test magic done");
  endtask
  task automatic t_link();
    h.wr(`WOLFD_OFS_CMD, 8'h02);
    h.wr(`WOLFD_OFS_PM, 8'h00);
    rchk(`WOLFD_OFS_CMD, 8'h02);
    rchk(`WOLFD_OFS_WAKE_CONTROL_STATUS, 8'h00);
    chk({6'h00, wake_mode, normal_rx_en}, 8'h02);
    h.page3();
    @(negedge ref_clk);
    phy_link = ~phy_link;
    repeat (3) @(negedge ref_clk);
    wchk(1'b1);
    rchk(`WOLFD_OFS_WAKE_CONTROL_STATUS, 8'h17);
    h.wr(`WOLFD_OFS_PM, 8'h00);
    chk({6'h00, wake_mode, normal_rx_en}, 8'h01);
    h.wr(`WOLFD_OFS_WAKE_CONTROL_STATUS, 8'h70);
    wchk(1'b0);
    phy_link = ~phy_link;
    repeat (3) @(negedge ref_clk);
    wchk(1'b0);
    $display("test link done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    repeat (4) @(negedge ref_clk);
    rstn = 1'b1;
    t_reset();
    t_frame();
    t_cascade();
    t_magic();
    t_link();
    print_verdict();
  end
endmodule
